// >>> bwc_pkg.sv
// Shared constants and types of the boot, erase-count and region configuration registers.
package bwc_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFF_BOOT = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_SECSEL = 8'h08;
  localparam logic [7:0] OFF_PTR4 = 8'h0c;
  localparam logic [7:0] OFF_PTR3 = 8'h10;
  localparam logic [7:0] OFF_PTR2 = 8'h14;
  localparam logic [7:0] OFF_PTR1 = 8'h18;
  localparam logic [7:0] OFF_BASE = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_MASK = 8'h24;
  // Boot configuration fields.
  localparam int BOOT_EN_BIT = 0;
  localparam int BOOT_DLY_LO = 1;
  localparam int BOOT_DLY_HI = 8;
  localparam int BOOT_ADR_LO = 9;
  localparam int BOOT_ADR_HI = 31;
  // Erase count fields.
  localparam int CNT_HI = 22;
  localparam int CNT_CORRUPT_BIT = 23;
  // Region pointer and base fields.
  localparam int PTR_EN_N_BIT = 0;
  localparam int PTR_TYPE_BIT = 1;
  localparam int PTR_SEC_LO = 2;
  localparam int PTR_SEC_HI = 10;
  localparam int BASE_WL_BIT = 0;
  localparam int BASE_GT_BIT = 1;
  // Status and mask bits.
  localparam int ST_BOOT = 0;
  localparam int ST_CORRUPT = 1;
  localparam int ST_ERASE = 2;
  localparam int SECTORS = 512;
  // Reset values.
  localparam logic [31:0] BOOT_RST = 32'h0000_0000;
  localparam logic [10:0] PTR_RST = 11'h7ff;
  localparam logic [1:0] BASE_RST = 2'h3;
  localparam logic [8:0] SECSEL_RST = 9'h000;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [22:0] CNT_MAX = 23'h7f_ffff;
  typedef enum logic [1:0] {
    BOOT_IDLE = 2'b00,
    BOOT_DELAY = 2'b01,
    BOOT_READ = 2'b11
  } bwc_boot_state_type;
endpackage : bwc_pkg

// >>> bwc_regs.sv
// Boot-read setup, sector erase counters and retention/endurance region registers behind APB.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
// Function
// - Boot read runs only when the enable bit is one; reset value disables it.
// - Boot read starts at the 23-bit address in bits 31 to 9.
// - Wait the 8-bit delay in bits 8 to 1 before boot data.
// - Boot read runs after hardware reset without a command; srst leaves it disabled, so none follows power-on.
// - A read-only 23-bit field reports erase count of the addressed sector.
// - Corrupt flag at bit 23 sets on reset count, clears on next good erase.
// - Each pointer holds a 9-bit first sector in bits 10 to 2.
// - Pointer bit 1 selects long retention (0) or high endurance (1), default 1.
// - Pointer bit 0 is an active-low enable; all pointers reset disabled.
// - Base bit 1 sets the type of sectors from sector 0 up to the lowest enabled pointer start.
// - Base bit 0 enables wear leveling; default enabled.
// - Four pointers plus the base divide memory into regions.
module bwc_regs
  import bwc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Hardware reset pin, asynchronous
  input wire logic hwResetN,
  // Boot read request to the array read path
  output logic bootReadReq,
  output logic [22:0] bootReadAddr,
  input wire logic bootReadAck,
  // Erase engine events
  input wire logic eraseDone,
  input wire logic eraseOk,
  input wire logic [8:0] eraseSector,
  input wire logic countCorrupt,
  input wire logic [8:0] corruptSector,
  // Region lookup
  input wire logic [8:0] regionQuerySector,
  output logic regionType,
  output logic wearLevelEn,
  // Interrupt
  output logic irq
);

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8+:8] = wd[b*8+:8];
      end
    end
    return r;
  endfunction : mergeBytes

  // The highest enabled pointer whose start lies at or below the sector decides the type.
  function automatic logic regionOf(input logic [8:0] sec, input logic [43:0] ptrs,
                                    input logic glob);
    logic t;
    logic hit;
    logic [8:0] best;
    logic [10:0] p;
    t = glob;
    hit = 1'b0;
    best = 9'h000;
    for (int i = 0; i < 4; i++) begin
      p = ptrs[i*11+:11];
      if (!p[PTR_EN_N_BIT] && p[PTR_SEC_HI:PTR_SEC_LO] <= sec &&
          (!hit || p[PTR_SEC_HI:PTR_SEC_LO] >= best)) begin
        hit = 1'b1;
        best = p[PTR_SEC_HI:PTR_SEC_LO];
        t = p[PTR_TYPE_BIT];
      end
    end
    return t;
  endfunction : regionOf

  logic [31:0] bootCfg_reg;
  logic [8:0] secSel_reg;
  logic [10:0] ptr_reg [4];
  logic [1:0] base_reg;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] mask_reg;
  logic [22:0] cntMem [SECTORS];
  logic [SECTORS-1:0] corruptMem;
  logic hwRstSync1_reg;
  logic hwRstSync2_reg;
  logic hwRstPrev_reg;
  logic porPending_reg;
  bwc_boot_state_type bootState_reg;
  logic [7:0] delayCnt_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic bootReadReq_reg;
  logic [22:0] bootReadAddr_reg;
  logic regionType_reg;
  logic wearLevelEn_reg;
  logic irq_reg;
  logic [31:0] readMux;
  logic addrOk;
  logic roWrite;
  logic setupCyc;
  logic wrEn;
  logic rdDone;
  logic bootTrig;
  logic bootDoneEv;
  logic corruptEv;
  logic eraseEv;
  int ptrIdx;

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign bootReadReq = bootReadReq_reg;
  assign bootReadAddr = bootReadAddr_reg;
  assign regionType = regionType_reg;
  assign wearLevelEn = wearLevelEn_reg;
  assign irq = irq_reg;

  assign setupCyc = psel && !penable;
  assign wrEn = psel && penable && pready_reg && pwrite && !pslverr_reg;
  assign rdDone = psel && penable && pready_reg && !pwrite && paddr == OFF_STATUS;
  assign corruptEv = countCorrupt;
  assign eraseEv = eraseDone && eraseOk;
  assign bootDoneEv = bootState_reg == BOOT_READ && bootReadAck;

  // Pointer registers sit at four consecutive words, pointer four first.
  always_comb begin
    ptrIdx = 0;
    unique case (paddr)
      OFF_PTR4: ptrIdx = 3;
      OFF_PTR3: ptrIdx = 2;
      OFF_PTR2: ptrIdx = 1;
      OFF_PTR1: ptrIdx = 0;
      default: ptrIdx = 0;
    endcase
  end

  always_comb begin
    readMux = 32'h0000_0000;
    addrOk = 1'b1;
    roWrite = 1'b0;
    unique case (paddr)
      OFF_BOOT: readMux = bootCfg_reg;
      OFF_COUNT: begin
        readMux[CNT_HI:0] = cntMem[secSel_reg];
        readMux[CNT_CORRUPT_BIT] = corruptMem[secSel_reg];
        roWrite = 1'b1;
      end
      OFF_SECSEL: readMux[8:0] = secSel_reg;
      OFF_PTR4, OFF_PTR3, OFF_PTR2, OFF_PTR1: readMux[10:0] = ptr_reg[ptrIdx];
      OFF_BASE: readMux[1:0] = base_reg;
      OFF_STATUS: readMux[2:0] = status_reg;
      OFF_MASK: readMux[2:0] = mask_reg;
      default: addrOk = 1'b0;
    endcase
  end

  // Zero wait states: the answer is registered in the setup cycle.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setupCyc;
      pslverr_reg <= setupCyc && (!addrOk || (pwrite && roWrite));
      prdata_reg <= (setupCyc && !pwrite) ? readMux : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bootCfg_reg <= BOOT_RST;
      secSel_reg <= SECSEL_RST;
      base_reg <= BASE_RST;
      mask_reg <= MASK_RST;
      for (int i = 0; i < 4; i++) begin
        ptr_reg[i] <= PTR_RST;
      end
    end else if (wrEn) begin
      unique case (paddr)
        OFF_BOOT: bootCfg_reg <= mergeBytes(bootCfg_reg, pwdata, pstrb);
        OFF_SECSEL: begin
          secSel_reg <= 9'(mergeBytes({23'h0, secSel_reg}, pwdata, pstrb));
        end
        OFF_PTR4, OFF_PTR3, OFF_PTR2, OFF_PTR1: begin
          ptr_reg[ptrIdx] <= 11'(mergeBytes({21'h0, ptr_reg[ptrIdx]}, pwdata, pstrb));
        end
        OFF_BASE: base_reg <= 2'(mergeBytes({30'h0, base_reg}, pwdata, pstrb));
        OFF_MASK: mask_reg <= 3'(mergeBytes({29'h0, mask_reg}, pwdata, pstrb));
        default: ;
      endcase
    end
  end

  // A corruption report on the same sector as a good erase wins: count reset, flag set.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      corruptMem <= '0;
      for (int s = 0; s < SECTORS; s++) begin
        cntMem[s] <= 23'h00_0000;
      end
    end else begin
      if (eraseEv) begin
        corruptMem[eraseSector] <= 1'b0;
        if (cntMem[eraseSector] != CNT_MAX) begin
          cntMem[eraseSector] <= cntMem[eraseSector] + 23'h00_0001;
        end
      end
      if (corruptEv) begin
        corruptMem[corruptSector] <= 1'b1;
        cntMem[corruptSector] <= 23'h00_0000;
      end
    end
  end

  // The pin is asynchronous; only the second stage and its one-cycle delayed copy are looked at.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hwRstSync1_reg <= 1'b0;
      hwRstSync2_reg <= 1'b0;
      hwRstPrev_reg <= 1'b0;
      porPending_reg <= 1'b1;
    end else begin
      hwRstSync1_reg <= hwResetN;
      hwRstSync2_reg <= hwRstSync1_reg;
      hwRstPrev_reg <= hwRstSync2_reg;
      porPending_reg <= 1'b0;
    end
  end

  // Release of the hardware reset pin starts a boot read; the power-on term meets a synchronizer still in reset and is ignored.
  assign bootTrig = porPending_reg || (hwRstSync2_reg && !hwRstPrev_reg);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bootState_reg <= BOOT_IDLE;
      delayCnt_reg <= 8'h00;
      bootReadReq_reg <= 1'b0;
      bootReadAddr_reg <= 23'h00_0000;
    end else if (!hwRstSync2_reg) begin
      bootState_reg <= BOOT_IDLE;
      bootReadReq_reg <= 1'b0;
    end else if (bootTrig && bootCfg_reg[BOOT_EN_BIT]) begin
      bootState_reg <= BOOT_DELAY;
      delayCnt_reg <= bootCfg_reg[BOOT_DLY_HI:BOOT_DLY_LO];
      bootReadAddr_reg <= bootCfg_reg[BOOT_ADR_HI:BOOT_ADR_LO];
      bootReadReq_reg <= 1'b0;
    end else begin
      unique case (bootState_reg)
        BOOT_IDLE: bootReadReq_reg <= 1'b0;
        BOOT_DELAY: begin
          if (delayCnt_reg == 8'h00) begin
            bootState_reg <= BOOT_READ;
            bootReadReq_reg <= 1'b1;
          end else begin
            delayCnt_reg <= delayCnt_reg - 8'h01;
          end
        end
        BOOT_READ: begin
          if (bootReadAck) begin
            bootState_reg <= BOOT_IDLE;
            bootReadReq_reg <= 1'b0;
          end
        end
        default: begin
          bootState_reg <= BOOT_IDLE;
          bootReadReq_reg <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      regionType_reg <= BASE_RST[BASE_GT_BIT];
      wearLevelEn_reg <= BASE_RST[BASE_WL_BIT];
    end else begin
      regionType_reg <= regionOf(regionQuerySector,
                                 {ptr_reg[3], ptr_reg[2], ptr_reg[1], ptr_reg[0]},
                                 base_reg[BASE_GT_BIT]);
      wearLevelEn_reg <= base_reg[BASE_WL_BIT];
    end
  end

  // Events set sticky bits; a read of status clears them, but a same-cycle event survives.
  always_comb begin
    status_next = rdDone ? 3'h0 : status_reg;
    status_next[ST_BOOT] = status_next[ST_BOOT] | bootDoneEv;
    status_next[ST_CORRUPT] = status_next[ST_CORRUPT] | corruptEv;
    status_next[ST_ERASE] = status_next[ST_ERASE] | eraseEv;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_reg <= 3'h0;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  boot_off_a: assert property (bootTrig && hwRstSync2_reg && !bootCfg_reg[BOOT_EN_BIT] &&
      bootState_reg == BOOT_IDLE |=> bootState_reg == BOOT_IDLE && !bootReadReq_reg)
    else $error("boot read started while disabled");
  boot_delay_a: assert property (bootTrig && hwRstSync2_reg && bootCfg_reg[BOOT_EN_BIT] &&
      bootCfg_reg[BOOT_DLY_HI:BOOT_DLY_LO] == 8'h03 ##1 (hwRstSync2_reg && !bootTrig)[*4]
      |=> bootReadReq_reg && bootReadAddr_reg == $past(bootCfg_reg[BOOT_ADR_HI:BOOT_ADR_LO], 5))
    else $error("boot read not issued after programmed delay");
  boot_start_a: assert property ($rose(bootReadReq_reg) |->
      $past(bootState_reg) == BOOT_DELAY && $past(delayCnt_reg) == 8'h00)
    else $error("boot read rose without completing delay");
  corrupt_set_a: assert property (corruptEv |=>
      corruptMem[$past(corruptSector)] && cntMem[$past(corruptSector)] == 23'h00_0000)
    else $error("corruption did not reset count and set flag");
  corrupt_clear_a: assert property (eraseEv && !(corruptEv && corruptSector == eraseSector) |=>
      !corruptMem[$past(eraseSector)])
    else $error("good erase did not clear corrupt flag");
  count_inc_a: assert property (eraseEv && !corruptEv && cntMem[eraseSector] != CNT_MAX |=>
      cntMem[$past(eraseSector)] == $past(cntMem[eraseSector]) + 23'h00_0001)
    else $error("erase count did not advance by one");
  global_region_a: assert property (ptr_reg[0][0] && ptr_reg[1][0] && ptr_reg[2][0] &&
      ptr_reg[3][0] |=> regionType_reg == $past(base_reg[BASE_GT_BIT]))
    else $error("global type not applied with all pointers off");
  ptr_region_a: assert property (!ptr_reg[0][0] && ptr_reg[1][0] && ptr_reg[2][0] && ptr_reg[3][0]
      && regionQuerySector >= ptr_reg[0][10:2] |=> regionType_reg == $past(ptr_reg[0][1]))
    else $error("enabled pointer type not applied");
  irq_level_a: assert property ((status_reg & mask_reg) != 3'h0 |=> irq_reg)
    else $error("interrupt missing for unmasked status");
  apb_ready_a: assert property (setupCyc |=> pready_reg ##1 !pready_reg)
    else $error("pready not a single cycle after setup");

  // A reset release with boot enabled must load the delay counter at once.
  boot_trig_a: assert property (bootTrig && hwRstSync2_reg && bootCfg_reg[BOOT_EN_BIT] |=>
      bootState_reg == BOOT_DELAY && delayCnt_reg == $past(bootCfg_reg[BOOT_DLY_HI:BOOT_DLY_LO]))
    else $error("boot read not started by reset release");
  // The host may be slow, so the request and its address stand until acknowledged.
  boot_hold_a: assert property (bootReadReq_reg && hwRstSync2_reg && !bootReadAck |=>
      bootReadReq_reg && $stable(bootReadAddr_reg))
    else $error("boot request or address dropped before acknowledge");
  irq_clear_a: assert property ((status_reg & mask_reg) == 3'h0 |=> !irq_reg)
    else $error("interrupt raised with no unmasked status");
  status_clear_a: assert property (rdDone && !bootDoneEv && !corruptEv && !eraseEv |=>
      status_reg == 3'h0)
    else $error("status read did not clear the sticky bits");
  apb_err_a: assert property (setupCyc && !addrOk |=> pready_reg && pslverr_reg && prdata_reg == 32'h0)
    else $error("unmapped access not refused");

  boot_run_c: cover property (bootState_reg == BOOT_READ ##1 bootState_reg == BOOT_IDLE);
  corrupt_c: cover property (corruptEv ##[1:20] eraseEv && eraseSector == $past(corruptSector));
  status_clear_c: cover property (irq_reg ##1 rdDone);
  region_hit_c: cover property (!ptr_reg[0][PTR_EN_N_BIT] && regionType_reg != base_reg[BASE_GT_BIT]);
  apb_err_c: cover property (pready_reg && pslverr_reg);

endmodule : bwc_regs

// >>> bwc_host_model.sv
// Host-side model that acknowledges boot read requests after a chosen wait.
`timescale 1ns/100ps
module bwc_host_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Boot handshake
  input wire logic bootReadReq,
  input wire logic [3:0] ackDelay,
  output logic bootReadAck
);
  logic [3:0] waitCnt_reg;
  // A slow host is modelled by holding the acknowledge off for ackDelay cycles.
  always_ff @(posedge ref_clk) begin
    if (srst || !bootReadReq || bootReadAck) begin
      bootReadAck <= 1'b0;
      waitCnt_reg <= 4'h0;
    end else if (waitCnt_reg == ackDelay) begin
      bootReadAck <= 1'b1;
    end else begin
      waitCnt_reg <= waitCnt_reg + 4'h1;
    end
  end
endmodule : bwc_host_model

// >>> tb.sv
// Self-checking testbench of the boot, erase-count and region registers.
`timescale 1ns/100ps
module tb
  import bwc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, hwResetN = 1'b1;
  logic bootReadReq, bootReadAck, regionType, wearLevelEn, irq;
  logic [22:0] bootReadAddr;
  logic eraseDone = 1'b0, eraseOk = 1'b0, countCorrupt = 1'b0;
  logic [8:0] eraseSector = 9'h0, corruptSector = 9'h0, regionQuerySector = 9'h0;
  logic [3:0] ackDelay = 4'h0;
  int n_fail = 0;
  int total_checks = 0;

  always #4 ref_clk = ~ref_clk;

  bwc_regs u_bwc_regs (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hwResetN(hwResetN), .bootReadReq(bootReadReq), .bootReadAddr(bootReadAddr), .bootReadAck(bootReadAck),
    .eraseDone(eraseDone), .eraseOk(eraseOk), .eraseSector(eraseSector), .countCorrupt(countCorrupt),
    .corruptSector(corruptSector), .regionQuerySector(regionQuerySector), .regionType(regionType),
    .wearLevelEn(wearLevelEn), .irq(irq));

  bwc_host_model u_bwc_host_model (.ref_clk(ref_clk), .srst(srst), .bootReadReq(bootReadReq),
    .ackDelay(ackDelay), .bootReadAck(bootReadAck));

  task close_out;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      chk(32'h0, 32'h1);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d, input logic experr);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk(e, experr);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk(e, experr);
  endtask : rdc

  task reset_values;
    logic [7:0] ptrOff [4];
    ptrOff = '{OFF_PTR4, OFF_PTR3, OFF_PTR2, OFF_PTR1};
    chk(regionType, 1'b1);
    chk(wearLevelEn, 1'b1);
    rdc(OFF_BOOT, 32'h0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rdc(ptrOff[i], 32'h7ff, 1'b0);
      wr(ptrOff[i], 32'hffff_fffd, 1'b0);
      rdc(ptrOff[i], 32'h7fd, 1'b0);
      wr(ptrOff[i], 32'h7ff, 1'b0);
    end
    rdc(OFF_BASE, 32'h3, 1'b0);
    rdc(OFF_COUNT, 32'h0, 1'b0);
    wr(OFF_COUNT, 32'h00ff_ffff, 1'b1);
    rdc(OFF_COUNT, 32'h0, 1'b0);
    rdc(8'h28, 32'h0, 1'b1);
    wr(OFF_BOOT, 32'hffff_fffe, 1'b0);
    rdc(OFF_BOOT, 32'hffff_fffe, 1'b0);
    wr(OFF_BOOT, 32'h0, 1'b0);
  endtask : reset_values

  task erase_ev(input logic [8:0] s, input logic ok, input logic c);
    @(posedge ref_clk);
    eraseDone <= !c;
    eraseOk <= ok;
    eraseSector <= s;
    countCorrupt <= c;
    corruptSector <= s;
    @(posedge ref_clk);
    eraseDone <= 1'b0;
    countCorrupt <= 1'b0;
  endtask : erase_ev

  task erase_counts;
    wr(OFF_MASK, 32'h0, 1'b0);
    wr(OFF_SECSEL, 32'h5, 1'b0);
    erase_ev(9'd5, 1'b1, 1'b0);
    erase_ev(9'd5, 1'b1, 1'b0);
    erase_ev(9'd6, 1'b1, 1'b0);
    erase_ev(9'd5, 1'b0, 1'b0);
    rdc(OFF_COUNT, 32'h2, 1'b0);
    chk(irq, 1'b0);
    rdc(OFF_STATUS, 32'h4, 1'b0);
    erase_ev(9'd5, 1'b0, 1'b1);
    rdc(OFF_COUNT, 32'h0080_0000, 1'b0);
    rdc(OFF_STATUS, 32'h2, 1'b0);
    erase_ev(9'd5, 1'b1, 1'b0);
    rdc(OFF_COUNT, 32'h1, 1'b0);
    wr(OFF_SECSEL, 32'h6, 1'b0);
    rdc(OFF_COUNT, 32'h1, 1'b0);
    rdc(OFF_STATUS, 32'h4, 1'b0);
  endtask : erase_counts

  task reg_chk(input logic [8:0] s, input logic e);
    @(posedge ref_clk);
    regionQuerySector <= s;
    repeat (2) @(posedge ref_clk);
    chk(regionType, e);
  endtask : reg_chk

  task regions;
    wr(OFF_BASE, 32'h0, 1'b0);
    repeat (2) @(posedge ref_clk);
    chk(wearLevelEn, 1'b0);
    reg_chk(9'd0, 1'b0);
    reg_chk(9'd511, 1'b0);
    wr(OFF_PTR1, 32'h0ca, 1'b0);
    reg_chk(9'd49, 1'b0);
    reg_chk(9'd50, 1'b1);
    wr(OFF_PTR2, 32'h140, 1'b0);
    reg_chk(9'd79, 1'b1);
    reg_chk(9'd80, 1'b0);
    wr(OFF_PTR4, 32'h143, 1'b0);
    reg_chk(9'd80, 1'b0);
    wr(OFF_PTR3, 32'h7fe, 1'b0);
    reg_chk(9'd510, 1'b0);
    reg_chk(9'd511, 1'b1);
    wr(OFF_BASE, 32'h3, 1'b0);
    reg_chk(9'd0, 1'b1);
    chk(wearLevelEn, 1'b1);
  endtask : regions

  // Pulses the hardware reset pin and waits for the boot read that follows.
  task boot_run(input logic [7:0] dly, input logic [22:0] adr, input logic [3:0] ackd);
    int n;
    ackDelay <= ackd;
    wr(OFF_MASK, 32'h7, 1'b0);
    wr(OFF_BOOT, {adr, dly, 1'b1}, 1'b0);
    @(posedge ref_clk);
    hwResetN <= 1'b0;
    repeat (4) @(posedge ref_clk);
    hwResetN <= 1'b1;
    n = 0;
    while (bootReadReq !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    chk(n >= dly + 3 && n <= dly + 7, 1'b1);
    chk(bootReadAddr, adr);
    n = 0;
    while (bootReadReq === 1'b1 && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    chk(n >= ackd + 1, 1'b1);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b1);
    rdc(OFF_STATUS, 32'h1, 1'b0);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b0);
    rdc(OFF_STATUS, 32'h0, 1'b0);
  endtask : boot_run

  task boot_off;
    int seen;
    wr(OFF_BOOT, 32'h0000_0010, 1'b0);
    @(posedge ref_clk);
    hwResetN <= 1'b0;
    repeat (4) @(posedge ref_clk);
    hwResetN <= 1'b1;
    seen = 0;
    repeat (40) begin
      @(posedge ref_clk);
      if (bootReadReq !== 1'b0)
        seen++;
    end
    chk(seen, 32'h0);
  endtask : boot_off

  initial begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    reset_values();
    erase_counts();
    regions();
    boot_run(8'h00, 23'h00_0001, 4'h0);
    boot_run(8'h05, 23'h7f_ffff, 4'h3);
    boot_run(8'h03, 23'h15_a5a5, 4'h2);
    boot_run(8'hff, 23'h2a_5a5a, 4'h1);
    boot_off();
    close_out();
  end

  // Whole run is well under a thousand cycles; this bound only cuts a hang short.
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    close_out();
  end
endmodule : tb
